// ### byte_buffer.sv
// Purpose: two-entry valid/ready buffer for received bytes.
// Assumes: single clock domain.
// Notes: full and empty reflect the real count.
`timescale 1ns/1ns
module byte_buffer (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire flash_pins_pkg::rx_byte_t in_data,
	output logic out_valid,
	input wire logic out_ready,
	output flash_pins_pkg::rx_byte_t out_data
);
	flash_pins_pkg::rx_byte_t mem [0:1];
	flash_pins_pkg::rx_byte_t next_mem0;
	flash_pins_pkg::rx_byte_t next_mem1;
	logic [1:0] count;
	logic [1:0] next_count;
	logic push;
	logic pop;

	always_comb begin
		push = in_valid && (count != 2'h2);
		pop = (count != 2'h0) && out_ready;
		next_count = count + {1'b0, push} - {1'b0, pop};
		next_mem0 = mem[0];
		next_mem1 = mem[1];
		if (pop) begin
			next_mem0 = mem[1];
		end
		if (push) begin
			if (count - {1'b0, pop} == 2'h0) begin
				next_mem0 = in_data;
			end else begin
				next_mem1 = in_data;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count <= 2'h0;
			mem[0] <= '0;
			mem[1] <= '0;
		end else begin
			count <= next_count;
			mem[0] <= next_mem0;
			mem[1] <= next_mem1;
		end
	end

	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data = mem[0];
endmodule

// ### flash_pin_if.sv
// Purpose: pin-level chip select framing, sampling and multi-I/O drive.
// Assumes: host serial clock is far slower than sys_clk and is sampled.
// Notes: bytes to send are supplied by the core one per byte boundary.
`timescale 1ns/1ns
module flash_pin_if (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic sel_n_pin,
	input wire logic sclk_pin,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	input wire logic quad_io_enable,
	input wire logic status_protect_bit_hi,
	input wire logic status_protect_bit_lo,
	input wire logic [1:0] read_width,
	input wire logic read_drive,
	input wire logic [7:0] tx_byte,
	input wire logic internal_busy,
	output logic rx_valid,
	input wire logic rx_ready,
	output flash_pins_pkg::rx_byte_t rx_data,
	output logic tx_take,
	output logic frame_start,
	output logic frame_end,
	output logic selected,
	output logic standby,
	output logic status_write_blocked
);
	////////////////////////////////////////////////////////////////////
	logic [1:0] sel_sync;
	logic [1:0] clk_sync;
	logic [3:0] io_s1;
	logic [3:0] io_s2;
	logic sel_d;
	logic clk_d;
	logic sel_n;
	logic sclk;
	logic sel_fall;
	logic sel_rise;
	logic sclk_rise;
	logic sclk_fall;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sel_sync <= 2'h3;
			clk_sync <= 2'h0;
			io_s1 <= 4'h0;
			io_s2 <= 4'h0;
			sel_d <= 1'b1;
			clk_d <= 1'b0;
		end else begin
			sel_sync <= {sel_sync[0], sel_n_pin};
			clk_sync <= {clk_sync[0], sclk_pin};
			io_s1 <= io_in;
			io_s2 <= io_s1;
			sel_d <= sel_sync[1];
			clk_d <= clk_sync[1];
		end
	end

	always_comb begin
		sel_n = sel_sync[1];
		sclk = clk_sync[1];
		sel_fall = sel_d && !sel_n;
		sel_rise = !sel_d && sel_n;
		sclk_rise = !clk_d && sclk && !sel_n;
		sclk_fall = clk_d && !sclk && !sel_n;
	end

	////////////////////////////////////////////////////////////////////
	// The status guard is a level decode; it only applies in hardware-protect mode.
	flash_pins_pkg::link_state_t state;
	flash_pins_pkg::link_state_t next_state;
	logic next_standby;
	logic next_selected;
	logic next_blocked;

	always_comb begin
		next_state = state;
		case (state)
			flash_pins_pkg::st_standby: begin
				if (sel_fall) begin
					next_state = flash_pins_pkg::st_active;
				end
			end
			flash_pins_pkg::st_active: begin
				if (sel_rise) begin
					next_state = internal_busy ? flash_pins_pkg::st_busy_wait
						: flash_pins_pkg::st_standby;
				end
			end
			flash_pins_pkg::st_busy_wait: begin
				if (sel_fall) begin
					next_state = flash_pins_pkg::st_active;
				end else if (!internal_busy) begin
					next_state = flash_pins_pkg::st_standby;
				end
			end
			default: begin
				next_state = flash_pins_pkg::st_standby;
			end
		endcase
		next_standby = (next_state == flash_pins_pkg::st_standby);
		next_selected = (next_state == flash_pins_pkg::st_active);
		next_blocked = !quad_io_enable && !status_protect_bit_hi
			&& status_protect_bit_lo && !io_s2[2];
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= flash_pins_pkg::st_standby;
			standby <= 1'b1;
			selected <= 1'b0;
			status_write_blocked <= 1'b0;
			frame_start <= 1'b0;
			frame_end <= 1'b0;
		end else begin
			state <= next_state;
			standby <= next_standby;
			selected <= next_selected;
			status_write_blocked <= next_blocked;
			frame_start <= sel_fall;
			frame_end <= sel_rise;
		end
	end

	////////////////////////////////////////////////////////////////////
	// A byte that finds the buffer full is held back; the host pacing makes this rare.
	logic [2:0] bit_count;
	logic [2:0] next_bit_count;
	logic [7:0] shift;
	logic [7:0] next_shift;
	logic first_pending;
	logic next_first_pending;
	logic push_valid;
	logic push_ready;
	flash_pins_pkg::rx_byte_t push_data;
	flash_pins_pkg::rx_byte_t next_push_data;
	logic next_push_valid;

	always_comb begin
		next_bit_count = bit_count;
		next_shift = shift;
		next_first_pending = first_pending;
		next_push_valid = push_valid && !push_ready;
		next_push_data = push_data;
		if (sel_fall) begin
			next_bit_count = flash_pins_pkg::bit_count_reset;
			next_shift = flash_pins_pkg::shift_reset;
			next_first_pending = 1'b1;
		end else if (sclk_rise && !read_drive) begin
			next_shift = {shift[6:0], io_s2[0]};
			next_bit_count = bit_count + 3'h1;
			if (bit_count == 3'h7) begin
				next_push_valid = 1'b1;
				next_push_data.data = {shift[6:0], io_s2[0]};
				next_push_data.first = first_pending;
				next_first_pending = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bit_count <= flash_pins_pkg::bit_count_reset;
			shift <= flash_pins_pkg::shift_reset;
			first_pending <= 1'b0;
			push_valid <= 1'b0;
			push_data <= '0;
		end else begin
			bit_count <= next_bit_count;
			shift <= next_shift;
			first_pending <= next_first_pending;
			push_valid <= next_push_valid;
			push_data <= next_push_data;
		end
	end

	flash_pins_pkg::rx_byte_t buf_data;
	logic buf_valid;

	byte_buffer rx_buf (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(buf_valid),
		.out_ready(rx_ready || !rx_valid),
		.out_data(buf_data)
	);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rx_valid <= 1'b0;
			rx_data <= '0;
		end else if (rx_ready || !rx_valid) begin
			rx_valid <= buf_valid;
			rx_data <= buf_data;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Output shifting on falling edges; lanes widen for multi-I/O reads.
	logic [7:0] tx_shift;
	logic [7:0] next_tx_shift;
	logic [2:0] tx_left;
	logic [2:0] next_tx_left;
	flash_pins_pkg::io_drive_t drive;
	flash_pins_pkg::io_drive_t next_drive;
	logic next_take;

	always_comb begin
		next_tx_shift = tx_shift;
		next_tx_left = tx_left;
		next_drive = drive;
		next_take = 1'b0;
		if (sel_n || sel_fall) begin
			next_drive = '0;
			next_tx_left = 3'h0;
		end else if (sclk_fall && read_drive) begin
			if (tx_left == 3'h0) begin
				next_tx_shift = tx_byte;
				next_take = 1'b1;
			end
			case (read_width)
				flash_pins_pkg::width_dual: begin
					next_drive.out = {2'h0, next_tx_shift[7:6]};
					next_drive.oe = 4'h3;
					next_tx_shift = {next_tx_shift[5:0], 2'h0};
					next_tx_left = (tx_left == 3'h0) ? 3'h3 : tx_left - 3'h1;
				end
				flash_pins_pkg::width_quad: begin
					next_drive.out = next_tx_shift[7:4];
					next_drive.oe = quad_io_enable ? 4'hf : 4'h3;
					next_tx_shift = {next_tx_shift[3:0], 4'h0};
					next_tx_left = (tx_left == 3'h0) ? 3'h1 : tx_left - 3'h1;
				end
				default: begin
					next_drive.out = {2'h0, next_tx_shift[7], 1'b0};
					next_drive.oe = 4'h2;
					next_tx_shift = {next_tx_shift[6:0], 1'b0};
					next_tx_left = (tx_left == 3'h0) ? 3'h7 : tx_left - 3'h1;
				end
			endcase
		end else if (!read_drive) begin
			next_drive = '0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tx_shift <= 8'h00;
			tx_left <= 3'h0;
			drive <= '0;
			tx_take <= 1'b0;
		end else begin
			tx_shift <= next_tx_shift;
			tx_left <= next_tx_left;
			drive <= next_drive;
			tx_take <= next_take;
		end
	end

	assign io_out = drive.out;
	assign io_oe = drive.oe;
endmodule

// ### flash_pin_if_asserts.sv
// Purpose: pin interface checker.
// Assumes: sees only the top module ports.
// Notes: config inputs are held steady during frames.
`timescale 1ns/1ns
module flash_pin_if_asserts (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic sel_n_pin,
	input wire logic sclk_pin,
	input wire logic [3:0] io_in,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe,
	input wire logic quad_io_enable,
	input wire logic status_protect_bit_hi,
	input wire logic status_protect_bit_lo,
	input wire logic [1:0] read_width,
	input wire logic read_drive,
	input wire logic [7:0] tx_byte,
	input wire logic internal_busy,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire flash_pins_pkg::rx_byte_t rx_data,
	input wire logic tx_take,
	input wire logic frame_start,
	input wire logic frame_end,
	input wire logic selected,
	input wire logic standby,
	input wire logic status_write_blocked
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	desel_hiz_a: assert property (!selected && !$past(selected) |-> io_oe == 4'h0)
		else $error("pins driven while deselected");
	sel_awake_a: assert property (selected |-> !standby)
		else $error("standby while selected");
	busy_defer_a: assert property ($rose(standby) |-> !$past(internal_busy))
		else $error("standby during busy");
	start_pulse_a: assert property (frame_start |=> !frame_start)
		else $error("frame start too long");
	end_pulse_a: assert property (frame_end |=> !frame_end && !selected)
		else $error("frame end wrong");
	take_sel_a: assert property (tx_take |-> selected ##1 !tx_take)
		else $error("byte taken while idle");
	quad_oe_a: assert property (io_oe[3:2] != 2'h0 |->
		quad_io_enable && read_width == flash_pins_pkg::width_quad)
		else $error("upper lines driven outside quad");
	rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
		else $error("received byte lost");
	wp_guard_a: assert property (status_write_blocked &&
		$stable({quad_io_enable, status_protect_bit_hi, status_protect_bit_lo}) |->
		!quad_io_enable && !status_protect_bit_hi && status_protect_bit_lo)
		else $error("guard in wrong mode");
endmodule
bind flash_pin_if flash_pin_if_asserts i_chk (.*);

// ### flash_pins_pkg.sv
// Purpose: constants and carrier types for the serial flash pin interface.
// Assumes: sys_clk at 25 MHz samples the host serial clock and pins.
// Notes: no software registers; configuration arrives on plain inputs.
package flash_pins_pkg;
	localparam int unsigned sys_clk_hz = 25000000;
	localparam int unsigned buf_depth = 2;
	localparam logic [1:0] width_single = 2'h0;
	localparam logic [1:0] width_dual = 2'h1;
	localparam logic [1:0] width_quad = 2'h2;
	localparam logic [2:0] bit_count_reset = 3'h0;
	localparam logic [7:0] shift_reset = 8'h00;

	typedef enum logic [1:0] {
		st_standby = 2'b00,
		st_active = 2'b01,
		st_busy_wait = 2'b10
	} link_state_t;

	typedef struct packed {
		logic [7:0] data;
		logic first;
	} rx_byte_t;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} io_drive_t;
endpackage

// ### host_spi_model.sv
// Purpose: host controller model.
// Assumes: mode 0, clock idles low outside frames.
// Notes: pins change on falling sys_clk edges.
`timescale 1ns/1ns
module host_spi_model (
	input wire logic sys_clk,
	input wire logic [3:0] io,
	output logic sel_n,
	output logic sclk,
	output logic mosi
);
	initial begin
		sel_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// Select edges alone frame an operation.
	task automatic sel(input logic v);
		wt(4);
		sel_n = v;
		wt(4);
	endtask
	// Data is sampled at the rise, half a period after the fall that set it.
	task automatic clk(input logic d, output logic [3:0] q);
		mosi = d;
		wt(4);
		sclk = 1'b1;
		q = io;
		wt(4);
		sclk = 1'b0;
	endtask
endmodule

// ### test_serial_flash_pin_interface.sv
// Purpose: self-checking bench for the pin interface.
// Assumes: sclk period 320 ns.
// Notes: released io[1], and io[0] during reads, show the inverse of io_out; io[2] shows wp and io[3] reads high.
`timescale 1ns/1ns
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_serial_flash_pin_interface;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic quad_io_enable = 1'b0;
	logic status_protect_bit_hi = 1'b0;
	logic status_protect_bit_lo = 1'b0;
	logic [1:0] read_width = 2'h0;
	logic read_drive = 1'b0;
	logic [7:0] tx_byte = 8'h00;
	logic internal_busy = 1'b0;
	logic rx_ready = 1'b1;
	logic wp = 1'b1;
	logic [3:0] q;
	logic [3:0] io_in, io_out, io_oe;
	logic sel_n_pin, sclk_pin, mosi, rx_valid, tx_take, frame_start, frame_end;
	logic selected, standby, status_write_blocked;
	flash_pins_pkg::rx_byte_t rx_data;
	int tests_run = 0;
	int miscompares = 0;
	int takes = 0;
	int starts = 0;
	int ends = 0;
	// Pulses are counted on the falling edge, where the registered outputs are settled.
	always @(negedge sys_clk) begin
		takes += int'(tx_take);
		starts += int'(frame_start);
		ends += int'(frame_end);
	end
	assign io_in[0] = io_oe[0] ? io_out[0] : (read_drive ? ~io_out[0] : mosi);
	assign io_in[1] = io_oe[1] ? io_out[1] : ~io_out[1];
	assign io_in[2] = io_oe[2] ? io_out[2] : wp;
	assign io_in[3] = io_oe[3] ? io_out[3] : 1'b1;
	host_spi_model h (.sys_clk, .io(io_in), .sel_n(sel_n_pin), .sclk(sclk_pin), .mosi);
	flash_pin_if i_dut (.sys_clk, .nrst, .sel_n_pin, .sclk_pin, .io_in, .io_out, .io_oe,
		.quad_io_enable, .status_protect_bit_hi, .status_protect_bit_lo, .read_width,
		.read_drive, .tx_byte, .internal_busy, .rx_valid, .rx_ready, .rx_data, .tx_take,
		.frame_start, .frame_end, .selected, .standby, .status_write_blocked);
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic tx8(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) h.clk(b[i], q);
	endtask
	task automatic t_rx;
		int s0;
		int e0;
		s0 = starts;
		e0 = ends;
		h.sel(1'b0);
		for (int i = 0; i < 3; i++) h.clk(1'b1, q);
		h.sel(1'b1);
		for (int i = 0; i < 6; i++) begin
			h.mosi = i[0];
			wt(2);
		end
		`CHK("rx idle", 1'b0, rx_valid)
		rx_ready = 1'b0;
		h.sel(1'b0);
		tx8(8'hA5);
		tx8(8'h3C);
		h.sel(1'b1);
		wt(10);
		`CHK("rx first", {1'b1, 8'hA5, 1'b1}, {rx_valid, rx_data})
		rx_ready = 1'b1;
		wt(1);
		`CHK("rx second", {1'b1, 8'h3C, 1'b0}, {rx_valid, rx_data})
		wt(1);
		`CHK("rx drained", 1'b0, rx_valid)
		`CHK("frame starts", s0 + 2, starts)
		`CHK("frame ends", e0 + 2, ends)
	endtask
	// The first sample comes at a rise before any fall has driven the lines, so it is thrown away.
	task automatic t_read(input logic [1:0] w, input int n, input logic [7:0] b);
		logic [7:0] got;
		int t0;
		t0 = takes;
		quad_io_enable = (n == 4);
		read_width = w;
		tx_byte = b;
		h.sel(1'b0);
		read_drive = 1'b1;
		h.clk(1'b0, q);
		for (int i = 0; i < 8 / n; i++) begin
			h.clk(1'b0, q);
			got = (n == 4) ? {got[3:0], q} : (n == 2) ? {got[5:0], q[1:0]} : {got[6:0], q[1]};
		end
		`CHK("read data", b, got)
		`CHK("read oe", (n == 4) ? 4'hF : (n == 2) ? 4'h3 : 4'h2, io_oe)
		h.sel(1'b1);
		read_drive = 1'b0;
		wt(2);
		`CHK("desel", {4'h0, 1'b1}, {io_oe, standby})
		`CHK("tx takes", t0 + 2, takes)
	endtask
	task automatic t_busy;
		internal_busy = 1'b1;
		h.sel(1'b0);
		`CHK("selected", 1'b1, selected)
		h.sel(1'b1);
		wt(20);
		`CHK("busy wait", 1'b0, standby)
		internal_busy = 1'b0;
		wt(6);
		`CHK("busy done", 1'b1, standby)
	endtask
	task automatic t_wp;
		status_protect_bit_lo = 1'b1;
		for (int i = 0; i < 8; i++) begin
			wp = i[0];
			quad_io_enable = i[1];
			status_protect_bit_hi = i[2];
			wt(6);
			`CHK("wp guard", i == 0, status_write_blocked)
		end
		wp = 1'b1;
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Whole run is near 20 us; the limit leaves wide margin.
	initial begin
		#400000;
		miscompares++;
		end_sim;
	end
	initial begin
		wt(2);
		nrst = 1'b1;
		wt(4);
		t_rx;
		t_read(flash_pins_pkg::width_single, 1, 8'h5A);
		t_read(flash_pins_pkg::width_dual, 2, 8'h96);
		t_read(flash_pins_pkg::width_quad, 4, 8'hC3);
		t_busy;
		t_wp;
		end_sim;
	end
endmodule
